/* core/occ_pkg.sv */
// Package for the clock source control registers
package occ_pkg;

  // APB register byte addresses
  localparam logic [11:0] OCC_ADDR_OSC  = 12'h000;
  localparam logic [11:0] OCC_ADDR_PLL  = 12'h004;
  localparam logic [11:0] OCC_ADDR_DIV  = 12'h008;
  localparam logic [11:0] OCC_ADDR_STAT = 12'h00c;
  localparam logic [11:0] OCC_ADDR_MASK = 12'h010;
  localparam logic [11:0] OCC_ADDR_MODE = 12'h014;

  // Reset values
  localparam logic [7:0] OCC_OSC_RESET = 8'h08;
  localparam logic [7:0] OCC_PLL_RESET = 8'h20;
  localparam logic [7:0] OCC_DIV_RESET = 8'h00;

  // Oscillator control field positions
  localparam int OCC_OSC_RUN_BIT     = 0;
  localparam int OCC_OSC_RESTART_BIT = 1;
  localparam int OCC_OSC_SRC_BIT     = 2;
  localparam int OCC_OSC_XPD_BIT     = 3;
  localparam int OCC_OSC_IPD_BIT     = 4;

  // Phase loop control field positions
  localparam int OCC_PLL_LOCK_BIT    = 0;
  localparam int OCC_PLL_RESTART_BIT = 1;
  localparam int OCC_PLL_DISC_BIT    = 2;
  localparam int OCC_PLL_BYP_BIT     = 3;
  localparam int OCC_PLL_FEEDBACK_DIVIDER_LSB    = 4;

  // Divider control field positions
  localparam int OCC_DIV_SLOW_LSB  = 0;
  localparam int OCC_DIV_VCO_BIT   = 7;

  // Feedback divider base and top legal code
  localparam logic [4:0] OCC_FEEDBACK_DIVIDER_BASE   = 5'h0e;
  localparam logic [3:0] OCC_FEEDBACK_DIVIDER_MAXCOD = 4'h7;
  // Highest legal slowdown code
  localparam logic [3:0] OCC_SLOW_MAXCOD = 4'hb;

  // Status event bit positions
  localparam int OCC_EV_RUN_UP    = 0;
  localparam int OCC_EV_RUN_DOWN  = 1;
  localparam int OCC_EV_LOCK_UP   = 2;
  localparam int OCC_EV_LOCK_LOSS = 3;
  localparam int OCC_EV_WIDTH     = 4;

  typedef enum logic [1:0]
  {
    OCC_MODE_PLL   = 2'b00,
    OCC_MODE_PRESC = 2'b01,
    OCC_MODE_BASE  = 2'b10
  } occ_mode_e;

  // Controls driven to the analog side
  typedef struct packed
  {
    logic       runDetectRestart;
    logic       oscSourceSelect;
    logic       crystalPowerDown;
    logic       internalOscPowerDown;
    logic       lockDetectRestart;
    logic       oscDisconnect;
    logic       vcoBypassSelect;
    logic [4:0] feedbackFactor;
    logic       vcoRangeSelect;
    occ_mode_e  clockMode;
  } occ_ctrl_s;

endpackage

/* core/occ_regs.sv */
// Clock source control and status registers with APB slave
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Oscillator control bit 0 reads run detection result, read only.
// - Writing 1 restarts run detection; bit self clears, writing 0 does nothing.
// - Source select bit 2: 0 on-chip oscillator, 1 external oscillator.
// - Bit 3 powers the crystal down when 1.
// - Bit 4 powers the on-chip oscillator down when 1.
// - Reserved bits of all three registers read 0; software writes 0.
// - Oscillator control resets to 08h; run flag appears one cycle after release.
// - Phase loop control resets to 20h; lock flag appears one cycle after release.
// - Phase loop control bit 0 reads lock state, read only.
// - Writing 1 to bit 1 clears lock flag, restarts detection; reads 0.
// - Bit 2 disconnects oscillator from the loop when 1.
// - Bit 3 bypasses the VCO when 1; normal operation when 0.
// - Bits 7:4 give feedback factor 14 plus code, codes 0 to 7.
// - Mode is loop, prescaler when bypassed, base whenever disconnected.
// - Range select 0 gives 150-200 MHz, 1 gives 100-150 MHz.
module occ_regs
  import occ_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  oscRunning,
  input  wire logic                  pllLocked,
  output occ_pkg::occ_ctrl_s         ctrl,
  output logic                       slowClkEn,
  output logic                       irq
);
  import occ_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed
  {
    logic [7:0]              osc;
    logic [7:0]              pll;
    logic [7:0]              div;
    logic [OCC_EV_WIDTH-1:0] stat;
    logic [OCC_EV_WIDTH-1:0] mask;
    logic                    runRst;
    logic                    lockRst;
    logic [10:0]             slowCnt;
    logic                    slowEn;
    logic [31:0]             rdata;
  } occ_state_s;

  occ_state_s s_q;
  occ_state_s s_d;

  logic       access;
  logic       wrEn;
  logic       mapped;
  logic [7:0] wb;
  logic [31:0] rmux;
  logic       setupRd;
  logic       oscWr;
  logic       pllWr;
  logic       divWr;
  logic       statWr;
  logic       maskWr;

  // Divide ratio minus one for a slowdown code
  function automatic logic [10:0] slowTop(input logic [3:0] code);
    logic [3:0] c;
    c = (code > OCC_SLOW_MAXCOD) ? OCC_SLOW_MAXCOD : code;
    slowTop = 11'((12'h001 << c) - 12'h001);
  endfunction

  // Rise in bit 0, fall in bit 1
  function automatic logic [1:0] flagEdges(input logic now, input logic was);
    flagEdges = {!now && was, now && !was};
  endfunction

  // Detector flag, held low for one cycle after a restart
  function automatic logic followFlag(input logic det, input logic restart);
    followFlag = det && !restart;
  endfunction

  // Address match for one register
  function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] regAddr);
    addrHit = (addr == regAddr);
  endfunction

  // Clock mode from disconnect and bypass
  function automatic occ_mode_e modeOf(input logic disc, input logic byp);
    if (disc)
    begin
      modeOf = OCC_MODE_BASE;
    end
    else if (byp)
    begin
      modeOf = OCC_MODE_PRESC;
    end
    else
    begin
      modeOf = OCC_MODE_PLL;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign access  = psel && penable;
  assign setupRd = psel && !penable && !pwrite;
  assign wrEn    = access && pwrite;
  assign wb      = pwdata[7:0];

  // Per register write strobes
  assign oscWr  = wrEn && addrHit(paddr, OCC_ADDR_OSC);
  assign pllWr  = wrEn && addrHit(paddr, OCC_ADDR_PLL);
  assign divWr  = wrEn && addrHit(paddr, OCC_ADDR_DIV);
  assign statWr = wrEn && addrHit(paddr, OCC_ADDR_STAT);
  assign maskWr = wrEn && addrHit(paddr, OCC_ADDR_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb
  begin
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    unique case (paddr)
      OCC_ADDR_OSC:
      begin
        rmux = {24'h000000, s_q.osc};
      end
      OCC_ADDR_PLL:
      begin
        rmux = {24'h000000, s_q.pll};
      end
      OCC_ADDR_DIV:
      begin
        rmux = {24'h000000, s_q.div};
      end
      OCC_ADDR_STAT:
      begin
        rmux = {28'h0000000, s_q.stat};
      end
      OCC_ADDR_MASK:
      begin
        rmux = {28'h0000000, s_q.mask};
      end
      OCC_ADDR_MODE:
      begin
        rmux = {30'h0000000, modeOf(s_q.pll[OCC_PLL_DISC_BIT], s_q.pll[OCC_PLL_BYP_BIT])};
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [OCC_EV_WIDTH-1:0] ev;
    ev = '0;
    s_d = s_q;
    s_d.runRst  = 1'b0;
    s_d.lockRst = 1'b0;
    // Status bits follow detectors only, held low while the restart strobe is set
    s_d.osc[OCC_OSC_RUN_BIT]  = followFlag(oscRunning, s_q.runRst);
    s_d.pll[OCC_PLL_LOCK_BIT] = followFlag(pllLocked, s_q.lockRst);

    // Detector edges
    {ev[OCC_EV_RUN_DOWN], ev[OCC_EV_RUN_UP]} =
      flagEdges(s_d.osc[OCC_OSC_RUN_BIT], s_q.osc[OCC_OSC_RUN_BIT]);
    {ev[OCC_EV_LOCK_LOSS], ev[OCC_EV_LOCK_UP]} =
      flagEdges(s_d.pll[OCC_PLL_LOCK_BIT], s_q.pll[OCC_PLL_LOCK_BIT]);

    // Oscillator control write
    if (oscWr)
    begin
      s_d.runRst = wb[OCC_OSC_RESTART_BIT];
      s_d.osc[OCC_OSC_SRC_BIT] = wb[OCC_OSC_SRC_BIT];
      s_d.osc[OCC_OSC_XPD_BIT] = wb[OCC_OSC_XPD_BIT];
      s_d.osc[OCC_OSC_IPD_BIT] = wb[OCC_OSC_IPD_BIT];
    end

    // Phase loop control write
    if (pllWr)
    begin
      s_d.lockRst = wb[OCC_PLL_RESTART_BIT];
      s_d.pll[OCC_PLL_DISC_BIT] = wb[OCC_PLL_DISC_BIT];
      s_d.pll[OCC_PLL_BYP_BIT]  = wb[OCC_PLL_BYP_BIT];
      s_d.pll[7:OCC_PLL_FEEDBACK_DIVIDER_LSB] = wb[7:OCC_PLL_FEEDBACK_DIVIDER_LSB];
    end

    // Divider control write
    if (divWr)
    begin
      s_d.div[OCC_DIV_VCO_BIT] = wb[OCC_DIV_VCO_BIT];
      s_d.div[3:OCC_DIV_SLOW_LSB] = wb[3:OCC_DIV_SLOW_LSB];
    end

    // Status write, one clears
    if (statWr)
    begin
      s_d.stat = s_q.stat & ~wb[OCC_EV_WIDTH-1:0];
    end

    // Mask write
    if (maskWr)
    begin
      s_d.mask = wb[OCC_EV_WIDTH-1:0];
    end

    // Set wins over clear
    s_d.stat = s_d.stat | ev;
    // Restart strobes and reserved bits always zero
    s_d.osc[OCC_OSC_RESTART_BIT] = 1'b0;
    s_d.pll[OCC_PLL_RESTART_BIT] = 1'b0;
    s_d.osc[7:5] = 3'h0;
    s_d.div[6:4] = 3'h0;
    // Slowdown enable divider
    if (s_q.slowCnt >= slowTop(s_q.div[3:0]))
    begin
      s_d.slowCnt = 11'h000;
      s_d.slowEn  = 1'b1;
    end
    else
    begin
      s_d.slowCnt = 11'(s_q.slowCnt + 11'h001);
      s_d.slowEn  = 1'b0;
    end

    // Read data taken in setup, stands through access
    if (setupRd)
    begin
      s_d.rdata = rmux;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q         <= '0;
      s_q.osc     <= OCC_OSC_RESET;
      s_q.pll     <= OCC_PLL_RESET;
      s_q.div     <= OCC_DIV_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = s_q.rdata;
  assign irq       = |(s_q.stat & s_q.mask);
  assign slowClkEn = s_q.slowEn;

  always_comb
  begin
    ctrl.runDetectRestart     = s_q.runRst;
    ctrl.oscSourceSelect      = s_q.osc[OCC_OSC_SRC_BIT];
    ctrl.crystalPowerDown     = s_q.osc[OCC_OSC_XPD_BIT];
    ctrl.internalOscPowerDown = s_q.osc[OCC_OSC_IPD_BIT];
    ctrl.lockDetectRestart    = s_q.lockRst;
    ctrl.oscDisconnect        = s_q.pll[OCC_PLL_DISC_BIT];
    ctrl.vcoBypassSelect      = s_q.pll[OCC_PLL_BYP_BIT];
    ctrl.feedbackFactor       = 5'(OCC_FEEDBACK_DIVIDER_BASE + {1'b0, s_q.pll[7:OCC_PLL_FEEDBACK_DIVIDER_LSB]});
    ctrl.vcoRangeSelect       = s_q.div[OCC_DIV_VCO_BIT];

    // Mode follows disconnect and bypass
    ctrl.clockMode = modeOf(s_q.pll[OCC_PLL_DISC_BIT], s_q.pll[OCC_PLL_BYP_BIT]);
  end

endmodule

`default_nettype wire

/* verif/occ_regs_checker.sv */
// Port assertions for the clock control registers
`timescale 1ns/1ns
`default_nettype none
module occ_regs_checker
  import occ_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire occ_pkg::occ_ctrl_s ctrl
);
  //////////////////////////////////////////////////
  wire logic wr = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_osc_restart: assert property (wr && paddr == OCC_ADDR_OSC && pwdata[1] |=> ctrl.runDetectRestart)
    else $error("osc restart missing");
  a_osc_pulse: assert property (ctrl.runDetectRestart |-> $past(wr && paddr == OCC_ADDR_OSC && pwdata[1]))
    else $error("osc restart unasked");
  a_pll_restart: assert property (wr && paddr == OCC_ADDR_PLL && pwdata[1] |=> ctrl.lockDetectRestart ##1 !ctrl.lockDetectRestart)
    else $error("pll restart pulse");
  a_osc_levels: assert property (wr && paddr == OCC_ADDR_OSC |=> ctrl.internalOscPowerDown == $past(pwdata[4])
    && ctrl.crystalPowerDown == $past(pwdata[3]) && ctrl.oscSourceSelect == $past(pwdata[2])) else $error("osc levels");
  a_pll_levels: assert property (wr && paddr == OCC_ADDR_PLL |=> ctrl.oscDisconnect == $past(pwdata[2])
    && ctrl.vcoBypassSelect == $past(pwdata[3])) else $error("pll levels");
  a_feedback_divider_factor: assert property (wr && paddr == OCC_ADDR_PLL |=> ctrl.feedbackFactor == 5'($past(pwdata[7:4])) + 5'h0e)
    else $error("feedback factor");
  a_mode_decode: assert property (ctrl.clockMode == (ctrl.oscDisconnect ? OCC_MODE_BASE :
    (ctrl.vcoBypassSelect ? OCC_MODE_PRESC : OCC_MODE_PLL))) else $error("clock mode");
  a_vco_range: assert property (wr && paddr == OCC_ADDR_DIV |=> ctrl.vcoRangeSelect == $past(pwdata[7]))
    else $error("vco range");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits");
endmodule
bind occ_regs occ_regs_checker u_occ_regs_checker (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ctrl(ctrl));
`default_nettype wire

/* verif/occ_analog_model.sv */
// Behavioural oscillator and phase loop core
`timescale 1ns/1ns
`default_nettype none
module occ_analog_model
  import occ_pkg::*;
(
  input  wire logic               clk,
  input  wire occ_pkg::occ_ctrl_s ctrl,
  input  wire logic               runOk,
  input  wire logic               lockOk,
  output logic                    oscRunning,
  output logic                    pllLocked
);
  logic [1:0] runWait = 2'h0;
  logic [1:0] lockWait = 2'h0;
  //////////////////////////////////////////////////
  always @(posedge clk)
  begin
    runWait <= ctrl.runDetectRestart ? 2'h3 : runWait - 2'(runWait != 2'h0);
    lockWait <= ctrl.lockDetectRestart ? 2'h3 : lockWait - 2'(lockWait != 2'h0);
    oscRunning <= runOk && runWait == 2'h0 && !ctrl.runDetectRestart
      && !(ctrl.oscSourceSelect ? ctrl.crystalPowerDown : ctrl.internalOscPowerDown);
    pllLocked <= lockOk && oscRunning && !ctrl.oscDisconnect && lockWait == 2'h0 && !ctrl.lockDetectRestart;
  end
endmodule
`default_nettype wire

/* verif/test_occ_regs.sv */
// Self-checking bench for the clock control registers
`timescale 1ns/1ns
`default_nettype none
module test_occ_regs;
  import occ_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, runOk = 1'b1, lockOk = 1'b1;
  logic        pready, pslverr, oscRunning, pllLocked, slowClkEn, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  o = 8'h08, p = 8'h20, v = 8'h00;
  logic [1:0]  md;
  occ_ctrl_s   ctrl;
  int          n_errors = 0, checks = 0, seed = 32'h77b5, cnt;
  always #20 clk = ~clk;
  //////////////////////////////////////////////////
  occ_regs u_occ_regs (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .oscRunning(oscRunning),
    .pllLocked(pllLocked), .ctrl(ctrl), .slowClkEn(slowClkEn), .irq(irq));
  occ_analog_model u_occ_analog_model (.clk(clk), .ctrl(ctrl), .runOk(runOk), .lockOk(lockOk),
    .oscRunning(oscRunning), .pllLocked(pllLocked));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    n_errors += int'(g !== e);
    if (g !== e)
      $display("ERROR %s expected %h seen %h", nm, e, g);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic chk_all();
    logic rn;
    rn = runOk && !(o[2] ? o[3] : o[4]);
    md = p[2] ? 2'h2 : {1'b0, p[3]};
    rdk("osc", OCC_ADDR_OSC, {27'h0, o[4:2], 1'b0, rn});
    rdk("pll", OCC_ADDR_PLL, {24'h0, p[7:2], 1'b0, lockOk && rn && !p[2]});
    rdk("div", OCC_ADDR_DIV, {24'h0, v[7], 3'h0, v[3:0]});
    rdk("mode", OCC_ADDR_MODE, {30'h0, md});
    chk("ctrl", {18'h0, o[2], o[3], o[4], 1'b0, p[2], p[3], 5'(p[7:4]) + 5'h0e, v[7], md}, 32'(ctrl));
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk_all();
    apb(1'b1, OCC_ADDR_OSC, o | 8'h02);
    rdk("oscRestart", OCC_ADDR_OSC, {24'h0, o & 8'h1c});
    apb(1'b1, OCC_ADDR_PLL, p | 8'h02);
    rdk("pllRestart", OCC_ADDR_PLL, {24'h0, p & 8'hfc});
    repeat (8) @(posedge clk);
    chk_all();
    repeat (16)
    begin
      o = 8'($random(seed)) & 8'hfd;
      p = 8'($random(seed)) & 8'h7d;
      v = 8'($random(seed)) & 8'hf7;
      apb(1'b1, OCC_ADDR_OSC, o);
      apb(1'b1, OCC_ADDR_PLL, p);
      apb(1'b1, OCC_ADDR_DIV, v);
      repeat (6) @(posedge clk);
      chk_all();
    end
    for (int i = 0; i < 5; i++)
    begin
      v = (i < 4) ? 8'(i) : 8'h0b;
      apb(1'b1, OCC_ADDR_DIV, v);
      repeat (16) @(posedge clk);
      cnt = 0;
      repeat (4096) @(posedge clk) cnt += int'(slowClkEn);
      chk("slowDiv", 32'(4096 >> v), 32'(cnt));
    end
    o = 8'h08;
    p = 8'h20;
    apb(1'b1, OCC_ADDR_OSC, o);
    apb(1'b1, OCC_ADDR_PLL, p);
    repeat (8) @(posedge clk);
    apb(1'b1, OCC_ADDR_STAT, 8'h0f);
    apb(1'b1, OCC_ADDR_MASK, 8'h02);
    runOk <= 1'b0;
    repeat (6) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdk("stat", OCC_ADDR_STAT, 32'h0a);
    apb(1'b1, OCC_ADDR_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("irqMasked", 32'h0, {31'h0, irq});
    apb(1'b1, OCC_ADDR_STAT, 8'h0a);
    rdk("statClr", OCC_ADDR_STAT, 32'h0);
    apb(1'b0, 12'h018, 8'h00);
    chk("badRead", 32'h0, rd);
    chk("badErr", 32'h1, {31'h0, err});
    wrap_up();
  end
endmodule
`default_nettype wire
